// [verilog/lan_status_consts.svh]
// Constants for the main status and interrupt flag register
`ifndef LAN_STATUS_CONSTS_SVH
`define LAN_STATUS_CONSTS_SVH

// Bit positions inside the main status/control register
`define BIT_OVERLENGTH      4'd14
`define BIT_MISSED_FRAME    4'd12
`define BIT_MEM_TIMEOUT     4'd11
`define BIT_RECEIVE_DONE    4'd10
`define BIT_TRANSMIT_DONE   4'd9
`define BIT_INIT_COMPLETE   4'd8
`define BIT_INTERRUPT_SUMMARY_SUMMARY    4'd7
`define BIT_INTERRUPT_SUMMARY_PIN_ENABLE 4'd6
`define BIT_RECEIVER_ACTIVE 4'd5
`define BIT_STOP            4'd2
`define BIT_START           4'd1
`define BIT_INIT            4'd0

// Register select codes and reset values
`define SEL_STATUS_MAIN     2'h0
`define RESET_SELECT        2'h0
`define RESET_STOP          1'b1
`define RESET_FLAG          1'b0
`define RESET_IRQ_N         1'b1
`define ZERO_WORD           16'h0000

// Bus-master ready timeout
`define CLK_PERIOD_NS       20'd50
`define MEM_TIMEOUT_NS      20'd25600
`define MEM_TIMEOUT_CYCLES  (`MEM_TIMEOUT_NS / `CLK_PERIOD_NS)
`define TIMEOUT_CNT_W       10

`endif

// [verilog/lan_status_pkg.sv]
// Types shared by the status flag register and its timeout watcher
package lan_status_pkg;
  typedef enum logic {
    WATCH_IDLE,
    WATCH_WAIT
  } watch_state_t;
endpackage : lan_status_pkg

// [verilog/mem_timeout_watch.sv]
// Ready acknowledge watchdog for bus-master address cycles
`include "lan_status_consts.svh"

module mem_timeout_watch
  import lan_status_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_addr_driven,
  input  wire logic i_ready_pin,
  output logic      o_timeout
);

  logic                      ready_meta_reg;
  logic                      ready_sync_reg;
  watch_state_t              state_reg;
  watch_state_t              state_next;
  logic [`TIMEOUT_CNT_W-1:0] count_reg;
  logic [`TIMEOUT_CNT_W-1:0] count_next;
  logic                      timeout_reg;
  logic                      timeout_next;

  localparam logic [`TIMEOUT_CNT_W-1:0] LAST_COUNT =
    `TIMEOUT_CNT_W'(`MEM_TIMEOUT_CYCLES - 1);

  // Two-stage synchroniser for the ready pin
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ready_meta_reg <= 1'b0;
      ready_sync_reg <= 1'b0;
    end else begin
      ready_meta_reg <= i_ready_pin;
      ready_sync_reg <= ready_meta_reg;
    end
  end

  // Count cycles from address drive until ready or expiry
  always_comb begin
    state_next   = state_reg;
    count_next   = count_reg;
    timeout_next = 1'b0;
    unique case (state_reg)
      WATCH_IDLE: begin
        if (i_addr_driven) begin
          state_next = WATCH_WAIT;
          count_next = '0;
        end
      end
      WATCH_WAIT: begin
        if (ready_sync_reg) begin
          state_next = WATCH_IDLE;
        end else if (count_reg == LAST_COUNT) begin
          state_next   = WATCH_IDLE;
          timeout_next = 1'b1;
        end else begin
          count_next = count_reg + 1'b1;
        end
      end
    endcase
  end

  // Register watcher state
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg   <= WATCH_IDLE;
      count_reg   <= '0;
      timeout_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      count_reg   <= count_next;
      timeout_reg <= timeout_next;
    end
  end

  assign o_timeout = timeout_reg;

endmodule // mem_timeout_watch

// [verilog/lan_status_interrupt_flags.sv]
// Main status register flags, summary interrupt and receiver-active state
`include "lan_status_consts.svh"

module lan_status_interrupt_flags
  import lan_status_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_bus_valid,
  input  wire logic        i_bus_write,
  input  wire logic        i_bus_adr,
  input  wire logic [15:0] i_bus_wdata,
  output logic      [15:0] o_bus_rdata,
  output logic             o_bus_ready,
  input  wire logic        i_frame_dropped,
  input  wire logic        i_rx_buf_owned,
  input  wire logic        i_silo_overflow,
  input  wire logic        i_tx_overlength,
  input  wire logic        i_rx_last_entry_done,
  input  wire logic        i_tx_done,
  input  wire logic        i_init_block_stored,
  input  wire logic        i_receiver_disable_option,
  input  wire logic        i_addr_driven,
  input  wire logic        i_ready_pin,
  output logic             o_ring_overflow_status,
  output logic             o_rx_tx_shutdown,
  output logic             o_init_request,
  output logic             o_receiver_active,
  output logic             o_irq_n
);

  // Event flags, control bits and port select
  logic        overlength_reg, overlength_next;
  logic        missed_reg, missed_next;
  logic        memto_reg, memto_next;
  logic        rxdone_reg, rxdone_next;
  logic        txdone_reg, txdone_next;
  logic        initc_reg, initc_next;
  logic        summary_reg, summary_next;
  logic        interrupt_pin_enable_reg, interrupt_pin_enable_next;
  logic        receiver_active_reg, receiver_active_next;
  logic        stop_reg, stop_next;
  logic        start_reg, start_next;
  logic        init_reg, init_next;
  logic        block_read_reg, block_read_next;
  logic [1:0]  select_reg, select_next;
  logic        irq_n_reg, irq_n_next;
  logic        shutdown_reg, shutdown_next;
  logic        init_req_reg, init_req_next;
  logic        ring_ovf_reg, ring_ovf_next;
  logic [15:0] rdata_reg, rdata_next;
  logic        ready_reg, ready_next;

  logic        mem_timeout;
  logic        wr_main;
  logic        wr_stop;
  logic        wr_go;
  logic [15:0] status_word;

  // Ready watchdog on bus-master address cycles
  mem_timeout_watch u_watch (
    .i_sys_clk     (i_sys_clk),
    .i_rst_n       (i_rst_n),
    .i_addr_driven (i_addr_driven),
    .i_ready_pin   (i_ready_pin),
    .o_timeout     (mem_timeout)
  );

  // Decode host writes to the main register
  assign wr_main = i_bus_valid & i_bus_write & ~i_bus_adr &
                   (select_reg == `SEL_STATUS_MAIN);
  assign wr_stop = wr_main & i_bus_wdata[`BIT_STOP];
  assign wr_go   = wr_main & ~i_bus_wdata[`BIT_STOP] &
                   (i_bus_wdata[`BIT_INIT] | i_bus_wdata[`BIT_START]);

  // Readback image of the main register
  always_comb begin
    status_word                       = `ZERO_WORD;
    status_word[`BIT_OVERLENGTH]      = overlength_reg;
    status_word[`BIT_MISSED_FRAME]    = missed_reg;
    status_word[`BIT_MEM_TIMEOUT]     = memto_reg;
    status_word[`BIT_RECEIVE_DONE]    = rxdone_reg;
    status_word[`BIT_TRANSMIT_DONE]   = txdone_reg;
    status_word[`BIT_INIT_COMPLETE]   = initc_reg;
    status_word[`BIT_INTERRUPT_SUMMARY_SUMMARY]    = summary_reg;
    status_word[`BIT_INTERRUPT_SUMMARY_PIN_ENABLE] = interrupt_pin_enable_reg;
    status_word[`BIT_RECEIVER_ACTIVE] = receiver_active_reg;
    status_word[`BIT_STOP]            = stop_reg;
    status_word[`BIT_START]           = start_reg;
    status_word[`BIT_INIT]            = init_reg;
  end

  // Sticky event flags: set wins over write-one, stop clears all
  always_comb begin
    overlength_next = (overlength_reg &
      ~(wr_main & i_bus_wdata[`BIT_OVERLENGTH])) | i_tx_overlength;
    missed_next = (missed_reg &
      ~(wr_main & i_bus_wdata[`BIT_MISSED_FRAME])) |
      (i_frame_dropped & ~i_rx_buf_owned & i_silo_overflow);
    memto_next = (memto_reg &
      ~(wr_main & i_bus_wdata[`BIT_MEM_TIMEOUT])) | mem_timeout;
    rxdone_next = (rxdone_reg &
      ~(wr_main & i_bus_wdata[`BIT_RECEIVE_DONE])) |
      i_rx_last_entry_done;
    txdone_next = (txdone_reg &
      ~(wr_main & i_bus_wdata[`BIT_TRANSMIT_DONE])) | i_tx_done;
    initc_next = (initc_reg &
      ~(wr_main & i_bus_wdata[`BIT_INIT_COMPLETE])) |
      (init_reg & i_init_block_stored);
    if (wr_stop) begin
      overlength_next = 1'b0;
      missed_next     = 1'b0;
      memto_next      = 1'b0;
      rxdone_next     = 1'b0;
      txdone_next     = 1'b0;
      initc_next      = 1'b0;
    end
  end

  // Stop, start, init control bits and init block tracking
  always_comb begin
    stop_next       = stop_reg;
    start_next      = start_reg;
    init_next       = init_reg;
    block_read_next = block_read_reg | (init_reg & i_init_block_stored);
    init_req_next   = 1'b0;
    if (wr_stop) begin
      stop_next       = 1'b1;
      start_next      = 1'b0;
      init_next       = 1'b0;
      block_read_next = 1'b0;
    end else if (wr_go) begin
      stop_next  = 1'b0;
      start_next = start_reg | i_bus_wdata[`BIT_START];
      if (i_bus_wdata[`BIT_INIT]) begin
        init_next       = 1'b1;
        block_read_next = 1'b0;
        init_req_next   = 1'b1;
      end
    end
  end

  // Pin enable, receiver-active, summary and interrupt pin
  always_comb begin
    interrupt_pin_enable_next = interrupt_pin_enable_reg;
    if (wr_stop) begin
      interrupt_pin_enable_next = 1'b0;
    end else if (wr_main & (~stop_reg | wr_go)) begin
      interrupt_pin_enable_next = i_bus_wdata[`BIT_INTERRUPT_SUMMARY_PIN_ENABLE];
    end
    receiver_active_next = receiver_active_reg;
    if (wr_go & i_bus_wdata[`BIT_START] & ~i_receiver_disable_option &
        (block_read_reg | (init_reg & i_init_block_stored))) begin
      receiver_active_next = 1'b1;
    end
    if (wr_stop | mem_timeout |
        (init_reg & i_init_block_stored & i_receiver_disable_option)) begin
      receiver_active_next = 1'b0;
    end
    summary_next = overlength_next | missed_next | memto_next |
                   rxdone_next | txdone_next | initc_next;
    irq_n_next    = ~(summary_next & interrupt_pin_enable_next);
    shutdown_next = mem_timeout;
    ring_ovf_next = i_silo_overflow & i_rx_buf_owned;
  end

  // Host port: select register and read data
  always_comb begin
    select_next = select_reg;
    rdata_next  = rdata_reg;
    ready_next  = i_bus_valid;
    if (i_bus_valid & i_bus_write & i_bus_adr) begin
      select_next = i_bus_wdata[1:0];
    end
    if (i_bus_valid & ~i_bus_write) begin
      if (i_bus_adr) begin
        rdata_next = {14'h0000, select_reg};
      end else if (select_reg == `SEL_STATUS_MAIN) begin
        rdata_next = status_word;
      end else begin
        rdata_next = `ZERO_WORD;
      end
    end
  end

  // Register all state
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      overlength_reg <= `RESET_FLAG;
      missed_reg     <= `RESET_FLAG;
      memto_reg      <= `RESET_FLAG;
      rxdone_reg     <= `RESET_FLAG;
      txdone_reg     <= `RESET_FLAG;
      initc_reg      <= `RESET_FLAG;
      summary_reg    <= `RESET_FLAG;
      interrupt_pin_enable_reg       <= `RESET_FLAG;
      receiver_active_reg       <= `RESET_FLAG;
      stop_reg       <= `RESET_STOP;
      start_reg      <= `RESET_FLAG;
      init_reg       <= `RESET_FLAG;
      block_read_reg <= `RESET_FLAG;
      select_reg     <= `RESET_SELECT;
      irq_n_reg      <= `RESET_IRQ_N;
      shutdown_reg   <= `RESET_FLAG;
      init_req_reg   <= `RESET_FLAG;
      ring_ovf_reg   <= `RESET_FLAG;
      rdata_reg      <= `ZERO_WORD;
      ready_reg      <= `RESET_FLAG;
    end else begin
      overlength_reg <= overlength_next;
      missed_reg     <= missed_next;
      memto_reg      <= memto_next;
      rxdone_reg     <= rxdone_next;
      txdone_reg     <= txdone_next;
      initc_reg      <= initc_next;
      summary_reg    <= summary_next;
      interrupt_pin_enable_reg       <= interrupt_pin_enable_next;
      receiver_active_reg       <= receiver_active_next;
      stop_reg       <= stop_next;
      start_reg      <= start_next;
      init_reg       <= init_next;
      block_read_reg <= block_read_next;
      select_reg     <= select_next;
      irq_n_reg      <= irq_n_next;
      shutdown_reg   <= shutdown_next;
      init_req_reg   <= init_req_next;
      ring_ovf_reg   <= ring_ovf_next;
      rdata_reg      <= rdata_next;
      ready_reg      <= ready_next;
    end
  end

  // Outputs straight from flip-flops
  assign o_bus_rdata            = rdata_reg;
  assign o_bus_ready            = ready_reg;
  assign o_ring_overflow_status = ring_ovf_reg;
  assign o_rx_tx_shutdown       = shutdown_reg;
  assign o_init_request         = init_req_reg;
  assign o_receiver_active      = receiver_active_reg;
  assign o_irq_n                = irq_n_reg;

endmodule // lan_status_interrupt_flags

// [dv/mem_ready_model.sv]
// Memory responder that answers the bus-master ready handshake
module mem_ready_model
  import lan_status_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_addr_driven,
  input  wire logic [7:0] i_delay,
  output logic            o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  // Ready rises i_delay-3 cycles after an address; delay 0 never answers
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 8'h00;
      o_ready <= 1'b0;
    end else begin
      if (i_addr_driven) cnt <= i_delay;
      else if (cnt != 8'h00) cnt <= cnt - 8'h01;
      o_ready <= (cnt >= 8'h01) && (cnt <= 8'h04);
    end
  end
endmodule // mem_ready_model

// [dv/lan_status_flags_props.sv]
// Port-level checker for the status flag register
module lan_status_flags_chk
  import lan_status_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic        i_bus_valid,
  input wire logic        i_bus_write,
  input wire logic        i_bus_adr,
  input wire logic [15:0] i_bus_wdata,
  input wire logic        o_bus_ready,
  input wire logic        i_rx_buf_owned,
  input wire logic        i_receiver_disable_option,
  input wire logic        i_addr_driven,
  input wire logic        o_ring_overflow_status,
  input wire logic        o_rx_tx_shutdown,
  input wire logic        o_receiver_active,
  input wire logic        o_irq_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic wr0;
  // Host write to the data port
  assign wr0 = i_bus_valid && i_bus_write && !i_bus_adr;
  a_ready_follows:
    assert property (i_bus_valid |=> o_bus_ready)
    else $error("ready missing after access");
  a_ready_caused:
    assert property (o_bus_ready |-> $past(i_bus_valid))
    else $error("ready without access");
  a_no_ring_report:
    assert property (!i_rx_buf_owned |=> !o_ring_overflow_status)
    else $error("ring status without owned entry");
  a_shutdown_single:
    assert property (o_rx_tx_shutdown |=> !o_rx_tx_shutdown)
    else $error("shutdown longer than one cycle");
  a_shutdown_rx_off:
    assert property (o_rx_tx_shutdown |-> !o_receiver_active)
    else $error("receiver still active on timeout");
  a_no_early_timeout:
    assert property (i_addr_driven |=> !o_rx_tx_shutdown [*8])
    else $error("timeout came too early");
  a_stop_clears:
    assert property (wr0 && i_bus_wdata[2] |=>
      o_irq_n && !o_receiver_active)
    else $error("stop did not clear state");
  a_rx_rise_start:
    assert property ($rose(o_receiver_active) |->
      $past(wr0 && i_bus_wdata[1] && !i_receiver_disable_option))
    else $error("receiver active without start");
  a_irq_stays_low:
    assert property (!o_irq_n && !i_bus_valid |=> !o_irq_n)
    else $error("interrupt dropped without host write");
  c_shutdown: cover property (o_rx_tx_shutdown);
  c_rx_on: cover property ($rose(o_receiver_active));
  c_irq: cover property ($fell(o_irq_n));
endmodule // lan_status_flags_chk

bind lan_status_interrupt_flags lan_status_flags_chk u_chk (
  .i_sys_clk, .i_rst_n, .i_bus_valid, .i_bus_write, .i_bus_adr, .i_bus_wdata,
  .o_bus_ready, .i_rx_buf_owned, .i_receiver_disable_option, .i_addr_driven,
  .o_ring_overflow_status, .o_rx_tx_shutdown, .o_receiver_active, .o_irq_n
);

// [dv/tb_lan_status_interrupt_flags.sv]
// Self-checking bench for the status flag register
module tb_lan_status_interrupt_flags
  import lan_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, valid, write, adr, own, silo, receiver_disable_option, adrv;
  logic        ready, rdy, shut, ireq, rxa_o, irq_n, ring, en, rxa;
  logic [15:0] wdata, rdata, q, f;
  logic [4:0]  ev;
  logic [7:0]  dly;
  int          error_cnt, n_compared, cyc;

  lan_status_interrupt_flags DUT (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_bus_valid(valid),
    .i_bus_write(write), .i_bus_adr(adr), .i_bus_wdata(wdata),
    .o_bus_rdata(rdata), .o_bus_ready(ready), .i_frame_dropped(ev[3]),
    .i_rx_buf_owned(own), .i_silo_overflow(silo), .i_tx_overlength(ev[4]),
    .i_rx_last_entry_done(ev[2]), .i_tx_done(ev[1]),
    .i_init_block_stored(ev[0]), .i_receiver_disable_option(receiver_disable_option),
    .i_addr_driven(adrv), .i_ready_pin(rdy), .o_ring_overflow_status(ring),
    .o_rx_tx_shutdown(shut), .o_init_request(ireq),
    .o_receiver_active(rxa_o), .o_irq_n(irq_n));
  mem_ready_model u_mem (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_addr_driven(adrv), .i_delay(dly), .o_ready(rdy));

  task automatic chk(input string n, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      error_cnt++;
    end
  endtask
  // One bus access with events pulsed in the same cycle
  task automatic step(input logic a, w, input logic [15:0] d,
                      input logic [4:0] e);
    @(negedge clk);
    {valid, write, adr, wdata, ev} = {1'b1, w, a, d, e};
    @(negedge clk);
    valid = 1'b0;
    ev = 5'h00;
    q = rdata;
    chk("ready", 16'h0001, {15'h0000, ready});
  endtask
  function automatic logic [15:0] word(input logic [15:0] fl);
    return fl | {8'h00, |fl, en, rxa, 5'h00};
  endfunction
  function automatic logic [15:0] set_of(input logic [4:0] e);
    return {1'b0, e[4], 1'b0, e[3] & !own & silo, 1'b0, e[2:0], 8'h00};
  endfunction
  task automatic rdchk;
    step(1'b0, 1'b0, 16'h0000, 5'h00);
    chk("csr", word(f), q & 16'hfff8);
    chk("irq_n", {15'h0000, !((|f) & en)}, {15'h0000, irq_n});
    chk("rx_active", {15'h0000, rxa}, {15'h0000, rxa_o});
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    logic [31:0] r;
    void'($urandom(62));
    {rst_n, valid, write, adr, wdata, ev, own, silo, receiver_disable_option, adrv} = '0;
    {dly, f, en, rxa} = '0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    step(1'b0, 1'b0, 16'h0000, 5'h00);
    chk("reset", 16'h0004, q);
    step(1'b0, 1'b1, 16'h0040, 5'h00);
    rdchk();
    step(1'b0, 1'b1, 16'h0041, 5'h00);
    chk("init_req", 16'h0001, {15'h0000, ireq});
    en = 1'b1;
    step(1'b0, 1'b0, 16'h0000, 5'h01);
    f = 16'h0100;
    rdchk();
    step(1'b0, 1'b1, 16'h0042, 5'h00);
    rxa = 1'b1;
    rdchk();
    for (int i = 0; i < 24; i++) begin
      r = $urandom;
      {own, silo} = r[1:0];
      step(1'b0, 1'b1, r[31:16] & 16'h5fe0, {r[5:2], 1'b0});
      chk("ring", {15'h0000, own & silo}, {15'h0000, ring});
      f = (f & ~(r[31:16] & 16'h5f00)) | set_of({r[5:2], 1'b0});
      en = r[22];
      rdchk();
    end
    step(1'b0, 1'b1, 16'h0040, 5'h00);
    en = 1'b1;
    for (int p = 0; p < 2; p++) begin
      dly = p ? 8'h00 : 8'h0a;
      @(negedge clk) adrv = 1'b1;
      @(negedge clk) adrv = 1'b0;
      for (int k = 0; k < 700 && !shut; k++) @(negedge clk);
      chk("shutdown", {15'h0000, p[0]}, {15'h0000, shut});
      if (p) f = f | 16'h0800;
      rxa = rxa & !p[0];
      rdchk();
    end
    step(1'b0, 1'b1, 16'h0004, 5'h00);
    {f, en, rxa} = '0;
    rdchk();
    step(1'b1, 1'b1, 16'h0001, 5'h00);
    step(1'b0, 1'b1, 16'h0001, 5'h00);
    step(1'b0, 1'b0, 16'h0000, 5'h00);
    chk("unmapped", 16'h0000, q);
    step(1'b1, 1'b0, 16'h0000, 5'h00);
    chk("select", 16'h0001, q);
    step(1'b1, 1'b1, 16'h0000, 5'h00);
    step(1'b0, 1'b0, 16'h0000, 5'h00);
    chk("stop_kept", 16'h0004, q);
    // Receiver disable option: start refused, init done clears rx
    receiver_disable_option = 1'b1;
    step(1'b0, 1'b1, 16'h0041, 5'h00);
    step(1'b0, 1'b0, 16'h0000, 5'h01);
    step(1'b0, 1'b1, 16'h0042, 5'h00);
    {f, en} = {16'h0100, 1'b1};
    rdchk();
    receiver_disable_option = 1'b0;
    step(1'b0, 1'b1, 16'h0042, 5'h00);
    rxa = 1'b1;
    rdchk();
    receiver_disable_option = 1'b1;
    step(1'b0, 1'b0, 16'h0000, 5'h01);
    rxa = 1'b0;
    rdchk();
    wrap_up();
  end
endmodule // tb_lan_status_interrupt_flags
